// file: rtl/rcc_run_ctrl.sv
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "rcc_defs.svh"

module rcc_run_ctrl #(
	parameter int PC_W = 16
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// Register port
	input  wire logic [`RCC_ADDR_W-1:0] i_addr,
	input  wire logic [15:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic      [15:0]            o_rdata,
	// Frame pulse sources, asynchronous levels
	input  wire logic [16:0]            i_rate_src,
	// Core handshake
	input  wire logic                   i_frame_done,
	// Core control
	output logic                        o_frame_start,
	output logic                        o_core_run,
	output logic                        o_pc_load,
	output logic      [PC_W-1:0]        o_pc_start,
	output logic                        o_irq_enable,
	output logic      [2:0]             o_status
);

	if (PC_W < 1 || PC_W > 16) begin : g_pc_w_check
		$error("rcc_run_ctrl: PC_W must be 1 to 16");
	end

	typedef struct packed {
		logic                  hib;
		logic [`RCC_SEL_W-1:0] sel;
		logic                  launch;
		logic                  abort;
		logic [15:0]           start_addr;
		logic                  launch_prev;
		logic                  abort_prev;
		rcc_pkg::rcc_state_e   fsm;
		logic                  pc_load;
		logic [15:0]           rdata;
	} rcc_regs_s;

	rcc_regs_s st;
	rcc_regs_s next_st;
	logic      pulse;
	logic      launch_edge;
	logic      abort_edge;
	logic [2:0] status;

	// -------------------------------------------------------------------------
	// Frame pulse selection.
	// -------------------------------------------------------------------------
	rcc_pulse_mux #(
		.SRC_N (17)
	) u_mux (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_src   (i_rate_src),
		.i_sel   (st.sel),
		.o_pulse (pulse)
	);

	// Edges compare each bit with its value one cycle earlier.
	assign launch_edge = st.launch & ~st.launch_prev;
	assign abort_edge  = st.abort & ~st.abort_prev;

	// Status follows the state being entered, so that it changes on the same
	// edge as the run output and never disagrees with it.
	always_comb begin
		case (next_st.fsm)
			rcc_pkg::RCC_RUN:   status = `RCC_ST_RUN;
			rcc_pkg::RCC_DRAIN: status = `RCC_ST_RUN;
			rcc_pkg::RCC_SLEEP: status = `RCC_ST_SLEEP;
			default:            status = `RCC_ST_IDLE;
		endcase
	end

	// -------------------------------------------------------------------------
	// Register writes, reads and run state.
	// -------------------------------------------------------------------------
	always_comb begin
		next_st             = st;
		next_st.launch_prev = st.launch;
		next_st.abort_prev  = st.abort;
		next_st.pc_load     = 1'b0;
		next_st.rdata       = `RCC_ZERO16;
		if (i_wr) begin
			if (i_addr == `RCC_OFS_HIBERNATE) begin
				next_st.hib = i_wdata[0];
			end else if (i_addr == `RCC_OFS_FRAME_SEL) begin
				next_st.sel = i_wdata[`RCC_SEL_W-1:0];
			end else if (i_addr == `RCC_OFS_LAUNCH) begin
				next_st.launch = i_wdata[0];
			end else if (i_addr == `RCC_OFS_ABORT) begin
				next_st.abort = i_wdata[0];
			end else if (i_addr == `RCC_OFS_START_ADDR) begin
				next_st.start_addr = i_wdata;
			end
		end
		if (i_rd) begin
			if (i_addr == `RCC_OFS_HIBERNATE) begin
				next_st.rdata = {15'h0000, st.hib};
			end else if (i_addr == `RCC_OFS_FRAME_SEL) begin
				next_st.rdata = {11'h000, st.sel};
			end else if (i_addr == `RCC_OFS_LAUNCH) begin
				next_st.rdata = {15'h0000, st.launch};
			end else if (i_addr == `RCC_OFS_ABORT) begin
				next_st.rdata = {15'h0000, st.abort};
			end else if (i_addr == `RCC_OFS_START_ADDR) begin
				next_st.rdata = st.start_addr;
			end else if (i_addr == `RCC_OFS_STATUS) begin
				next_st.rdata = {13'h0000, o_status};
			end
		end

		// Halt has top priority and may strike mid-frame; that is why it can
		// leave memory inconsistent and is meant for debug only.
		if (abort_edge || st.abort) begin
			next_st.fsm = rcc_pkg::RCC_IDLE;
		end else begin
			case (st.fsm)
				rcc_pkg::RCC_IDLE: begin
					// A falling start bit and a cleared halt bit do nothing
					// here; only a fresh rising start edge launches.
					if (launch_edge) begin
						next_st.fsm     = st.hib ? rcc_pkg::RCC_SLEEP
						                         : rcc_pkg::RCC_RUN;
						next_st.pc_load = 1'b1;
					end
				end
				rcc_pkg::RCC_RUN: begin
					if (st.hib) begin
						next_st.fsm = rcc_pkg::RCC_DRAIN;
					end
				end
				rcc_pkg::RCC_DRAIN: begin
					if (i_frame_done) begin
						next_st.fsm = rcc_pkg::RCC_SLEEP;
					end
				end
				rcc_pkg::RCC_SLEEP: begin
					if (!st.hib) begin
						next_st.fsm = rcc_pkg::RCC_RUN;
					end
				end
				default: next_st.fsm = rcc_pkg::RCC_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st     <= '0;
			st.sel <= `RCC_SEL_RESET;
			st.fsm <= rcc_pkg::RCC_IDLE;
			o_frame_start <= 1'b0;
			o_core_run    <= 1'b0;
			o_irq_enable  <= 1'b1;
			o_status      <= `RCC_ST_IDLE;
			o_pc_start    <= '0;
		end else begin
			st <= next_st;
			// Frames start only on the chosen pulse; unrelated audio must be
			// converted upstream or samples slip.
			o_frame_start <= pulse & (next_st.fsm == rcc_pkg::RCC_RUN);
			o_core_run    <= (next_st.fsm == rcc_pkg::RCC_RUN) ||
			                 (next_st.fsm == rcc_pkg::RCC_DRAIN);
			// Interrupts follow the stored bit so they return on the same edge
			// as the core leaves sleep.
			o_irq_enable  <= ~st.hib;
			o_status      <= status;
			if (next_st.pc_load) begin
				o_pc_start <= st.start_addr[PC_W-1:0];
			end
		end
	end

	assign o_pc_load = st.pc_load;
	assign o_rdata   = st.rdata;

endmodule // rcc_run_ctrl

// file: rtl/rcc_defs.svh
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH
// Behaviour
// - Five-bit frame pulse selector in low bits, reset selects base rate.
// - Codes 0 to 4 pick generator one at quarter, half, one, two, four.
// - Codes 5 to 7 pick generator two: divide six, three, two-thirds.
// - Codes 8 to 11 pick serial input ports zero to three.
// - Codes 12 to 15 pick serial output ports zero to three.
// - Code 16 picks the receiver recovered stream rate.
// - Unsynchronised unconverted audio drops or repeats samples.
// - Rising start bit enables core and launches the program counter.
// - Falling start bit does nothing; it cannot stop execution.
// - Rising halt bit stops the core at once, from any state.
// - Core stays stopped while the halt bit stays set.
// - Clearing halt only permits a later restart by a start edge.
// - Hibernate request finishes current sample, then sleeps, interrupts off.
// - Program counter begins at the program start address register.
// - After halt or at boot the status field reports not running, 000.

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define RCC_ADDR_W         16
`define RCC_OFS_HIBERNATE  16'hf400
`define RCC_OFS_FRAME_SEL  16'hf401
`define RCC_OFS_LAUNCH     16'hf402
`define RCC_OFS_ABORT      16'hf403
`define RCC_OFS_START_ADDR 16'hf404
`define RCC_OFS_STATUS     16'hf405

// -----------------------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------------------
`define RCC_SEL_W          5
`define RCC_SEL_RESET      5'h02
`define RCC_SEL_SRC_MAX    5'h10
`define RCC_ST_IDLE        3'h0
`define RCC_ST_RUN         3'h1
`define RCC_ST_SLEEP       3'h3
`define RCC_ZERO16         16'h0000

`endif

// file: rtl/rcc_pkg.sv
package rcc_pkg;

	typedef enum {
		RCC_IDLE,
		RCC_RUN,
		RCC_DRAIN,
		RCC_SLEEP
	} rcc_state_e;

	typedef struct packed {
		logic        pulse;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} rcc_bus_s;

endpackage

// file: rtl/rcc_pulse_mux.sv
`timescale 1ns/100ps
`include "rcc_defs.svh"

module rcc_pulse_mux #(
	parameter int SRC_N = 17
) (
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	// Pulse sources and choice
	input  wire logic [SRC_N-1:0]      i_src,
	input  wire logic [`RCC_SEL_W-1:0] i_sel,
	// Selected frame start
	output logic                       o_pulse
);

	if (SRC_N != 17) begin : g_src_n_check
		$error("rcc_pulse_mux: seventeen sources are required");
	end

	typedef struct packed {
		logic [SRC_N-1:0] sync1;
		logic [SRC_N-1:0] sync2;
		logic [SRC_N-1:0] prev;
		logic             pulse;
	} rcc_mux_s;

	rcc_mux_s st;
	rcc_mux_s next_st;

	// -------------------------------------------------------------------------
	// Sources are rate-clock levels from other domains; a rising edge of the
	// chosen one becomes a single frame start. Unknown codes give no pulse.
	// -------------------------------------------------------------------------
	always_comb begin
		next_st       = st;
		next_st.sync1 = i_src;
		next_st.sync2 = st.sync1;
		next_st.prev  = st.sync2;
		next_st.pulse = 1'b0;
		if (i_sel <= `RCC_SEL_SRC_MAX) begin
			// Codes map in order onto generator one, generator two, input ports,
			// output ports and the receiver rate.
			next_st.pulse = st.sync2[i_sel] & ~st.prev[i_sel];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_pulse = st.pulse;

endmodule // rcc_pulse_mux

// file: bench/rcc_run_ctrl_asserts.sv
`timescale 1ns/100ps
`include "rcc_defs.svh"
module rcc_run_ctrl_asserts #(
	parameter int PC_W = 16
) (
	input wire logic            i_clk,
	input wire logic            i_rst,
	input wire logic [15:0]     i_addr,
	input wire logic [15:0]     i_wdata,
	input wire logic            i_wr,
	input wire logic            i_rd,
	input wire logic [15:0]     o_rdata,
	input wire logic [16:0]     i_rate_src,
	input wire logic            i_frame_done,
	input wire logic            o_frame_start,
	input wire logic            o_core_run,
	input wire logic            o_pc_load,
	input wire logic [PC_W-1:0] o_pc_start,
	input wire logic            o_irq_enable,
	input wire logic [2:0]      o_status
);
// ----------------------------------------
// Shadow copies of the control registers
// ----------------------------------------
logic [4:0] sel;
logic [15:0] sa;
logic lch, hlt, hib;
logic [2:0] age;
wire lw = i_wr && i_addr == `RCC_OFS_LAUNCH;
wire aw = i_wr && i_addr == `RCC_OFS_ABORT;
always_ff @(posedge i_clk) begin
	if (i_rst) begin
		{sel, lch, hlt, hib, sa, age} <= {5'h02, 22'h0};
	end else begin
		if (i_wr && i_addr == `RCC_OFS_FRAME_SEL) sel <= i_wdata[4:0];
		if (i_wr && i_addr == `RCC_OFS_START_ADDR) sa <= i_wdata;
		if (i_wr && i_addr == `RCC_OFS_HIBERNATE) hib <= i_wdata[0];
		if (lw) lch <= i_wdata[0];
		if (aw) hlt <= i_wdata[0];
		if (!hlt) age <= 3'h0;
		else if (age != 3'h7) age <= age + 3'h1;
	end
end
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
AST_RESET: assert property ($fell(i_rst) |-> o_status == 3'h0
	&& !o_core_run && !o_pc_load && o_irq_enable) else $error("reset state");
AST_SEL_READ: assert property (i_rd && i_addr == `RCC_OFS_FRAME_SEL
	|=> o_rdata == {11'h0, sel}) else $error("selector readback");
AST_LAUNCH: assert property (lw && i_wdata[0] && !lch && !hlt && !hib
	&& o_status == 3'h0 |-> ##[1:4] o_pc_load) else $error("no launch");
AST_PC_PULSE: assert property (o_pc_load |=> !o_pc_load)
	else $error("pc load not a pulse");
AST_PC_START: assert property (o_pc_load |-> ##[0:1]
	o_pc_start == sa[PC_W-1:0]) else $error("start address");
AST_HALT_STOP: assert property (aw && i_wdata[0] |-> ##[1:4]
	!o_core_run && o_status == 3'h0) else $error("halt too slow");
AST_HALT_HOLD: assert property (hlt && age >= 3'h5 |->
	!o_core_run && !o_pc_load && o_status == 3'h0) else $error("ran halted");
AST_FALL_NOP: assert property (lw && !i_wdata[0] && !hlt && !hib
	&& o_status == 3'h1 |=> o_core_run [*2]) else $error("falling stops");
AST_SLEEP: assert property (o_status == 3'h3 |->
	!o_core_run && !o_irq_enable) else $error("sleep outputs");
COV_LAUNCH: cover property (o_pc_load);
COV_SLEEP: cover property (o_status == 3'h3);
COV_FRAME: cover property (o_frame_start);
endmodule // rcc_run_ctrl_asserts
bind rcc_run_ctrl rcc_run_ctrl_asserts #(.PC_W(PC_W)) i_rcc_run_ctrl_asserts (
	.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rate_src(i_rate_src),
	.i_frame_done(i_frame_done), .o_frame_start(o_frame_start),
	.o_core_run(o_core_run), .o_pc_load(o_pc_load), .o_pc_start(o_pc_start),
	.o_irq_enable(o_irq_enable), .o_status(o_status));

// file: bench/test_rcc_run_ctrl.sv
`timescale 1ns/100ps
`include "rcc_defs.svh"
module test_rcc_run_ctrl;
// ----------------------------------------
// Register access, waits and checks
// ----------------------------------------
logic i_clk, i_rst, i_wr, i_rd, i_frame_done;
logic o_frame_start, o_core_run, o_pc_load, o_irq_enable;
logic [15:0] i_addr, i_wdata, o_rdata, o_pc_start;
logic [16:0] i_rate_src;
logic [2:0] o_status;
int n_mismatch = 0;
int samples_checked = 0;
int k, c;
rcc_run_ctrl i_rcc_run_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_rate_src(i_rate_src), .i_frame_done(i_frame_done),
	.o_frame_start(o_frame_start), .o_core_run(o_core_run),
	.o_pc_load(o_pc_load), .o_pc_start(o_pc_start),
	.o_irq_enable(o_irq_enable), .o_status(o_status));
initial begin
	i_clk = 1'b0;
	forever #5 i_clk = ~i_clk;
end
task stop_test;
	$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
	if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
	else $display("Result: failed");
	$finish;
endtask
task chk(input string n, input logic [15:0] s, e);
	samples_checked++;
	if (s !== e) begin
		n_mismatch++;
		$display("Error: %s expected %h seen %h", n, e, s);
	end
endtask
task wr(input logic [15:0] a, d);
	@(posedge i_clk);
	i_addr <= a;
	i_wdata <= d;
	i_wr <= 1'b1;
	@(posedge i_clk);
	i_wr <= 1'b0;
endtask
task rd(input logic [15:0] a, e, input string n);
	@(posedge i_clk);
	i_addr <= a;
	i_rd <= 1'b1;
	@(posedge i_clk);
	i_rd <= 1'b0;
	#1 chk(n, o_rdata, e);
endtask
// Pulses are short, so every cycle is looked at until the signal shows or 20 cycles pass.
task wt(input int s);
	for (k = 0; k < 20; k++) begin
		@(posedge i_clk);
		#1;
		if ((s == 0 ? o_pc_load : s == 1 ? o_core_run : s == 2 ?
			o_frame_start : o_status == 3'h3) === 1'b1) break;
	end
	if (k == 20) begin
		n_mismatch++;
		$display("Error: wait %0d expected 1 seen 0", s);
		stop_test;
	end
endtask
initial begin
	{i_rst, i_wr, i_rd, i_frame_done} = 4'h8;
	{i_addr, i_wdata, i_rate_src} = '0;
	repeat (5) @(posedge i_clk);
	i_rst <= 1'b0;
	rd(`RCC_OFS_FRAME_SEL, 16'h0002, "sel");
	rd(`RCC_OFS_STATUS, 16'h0000, "status");
	rd(16'hf406, 16'h0000, "unmapped");
	chk("irq_en", 16'(o_irq_enable), 16'h1);
	wr(`RCC_OFS_FRAME_SEL, 16'hffff);
	rd(`RCC_OFS_FRAME_SEL, 16'h001f, "sel");
	wr(`RCC_OFS_STATUS, 16'hffff);
	rd(`RCC_OFS_STATUS, 16'h0000, "status");
	$display("registers done");
	wr(`RCC_OFS_START_ADDR, 16'h1234);
	wr(`RCC_OFS_LAUNCH, 16'h0001);
	wt(0);
	chk("pc_start", o_pc_start, 16'h1234);
	wt(1);
	chk("status", 16'(o_status), 16'h1);
	$display("launch done");
	for (c = 0; c < 17; c++) begin
		wr(`RCC_OFS_FRAME_SEL, 16'(c));
		i_rate_src[(c + 1) % 17] <= 1'b1;
		k = 0;
		repeat (10) begin
			@(posedge i_clk);
			#1 k += o_frame_start;
		end
		@(posedge i_clk);
		i_rate_src <= '0;
		chk("stray", 16'(k), 16'h0);
		@(posedge i_clk);
		i_rate_src[c] <= 1'b1;
		wt(2);
		@(posedge i_clk);
		i_rate_src <= '0;
		repeat (8) @(posedge i_clk);
	end
	wr(`RCC_OFS_FRAME_SEL, 16'h001f);
	i_rate_src <= 17'h1ffff;
	k = 0;
	repeat (10) begin
		@(posedge i_clk);
		#1 k += o_frame_start;
	end
	@(posedge i_clk);
	i_rate_src <= '0;
	chk("unknown code", 16'(k), 16'h0);
	$display("frame select done");
	wr(`RCC_OFS_LAUNCH, 16'h0000);
	repeat (4) @(posedge i_clk);
	#1 chk("run", 16'(o_core_run), 16'h1);
	wr(`RCC_OFS_HIBERNATE, 16'h0001);
	repeat (4) @(posedge i_clk);
	#1 chk("drain run", 16'(o_core_run), 16'h1);
	chk("drain status", 16'(o_status), 16'h1);
	@(posedge i_clk);
	i_frame_done <= 1'b1;
	wt(3);
	chk("irq_en", 16'(o_irq_enable), 16'h0);
	chk("sleep run", 16'(o_core_run), 16'h0);
	@(posedge i_clk);
	i_frame_done <= 1'b0;
	wr(`RCC_OFS_HIBERNATE, 16'h0000);
	wt(1);
	$display("hibernate done");
	wr(`RCC_OFS_ABORT, 16'h0001);
	repeat (4) @(posedge i_clk);
	#1 chk("status", 16'(o_status), 16'h0);
	wr(`RCC_OFS_LAUNCH, 16'h0001);
	wr(`RCC_OFS_ABORT, 16'h0000);
	repeat (6) @(posedge i_clk);
	#1 chk("run", 16'(o_core_run), 16'h0);
	wr(`RCC_OFS_LAUNCH, 16'h0000);
	wr(`RCC_OFS_LAUNCH, 16'h0001);
	wt(1);
	$display("halt done");
	@(posedge i_clk);
	i_rst <= 1'b1;
	repeat (2) @(posedge i_clk);
	i_rst <= 1'b0;
	#1 chk("status", 16'(o_status), 16'h0);
	chk("run", 16'(o_core_run), 16'h0);
	chk("irq_en", 16'(o_irq_enable), 16'h1);
	rd(`RCC_OFS_FRAME_SEL, 16'h0002, "sel");
	$display("reset done");
	stop_test;
end
endmodule // test_rcc_run_ctrl
